/* shared/ppa_pkg.sv */
// Contract
// - policy 0: precharge addressed bank on miss
// - policy 1: precharge all on miss
// - precharge all on open-page row change
// - precharge all before every refresh
// - frequency bit: 0 is 100, 1 is 133 MHz
// - frequency default sampled from strap at reset
// - lock bit written once per reset
// - lock set makes graphics select read-only
// - aperture enable 0 blocks all aperture accesses
// - select 0: devices 0,1 visible, 2 ones
// - select 1: device 1 ones, port regs zero
// - internal graphics needs smm field and select
package ppa_pkg;
  localparam logic [7:0] POLICY_REG_OFS   = 8'h50;
  localparam logic [7:0] APERTURE_REG_OFS = 8'h51;
  localparam logic [7:0] SMM_REG_OFS      = 8'h70;
  localparam int POLICY_BIT   = 3;
  localparam int FREQ_BIT     = 2;
  localparam int LOCK_BIT     = 2;
  localparam int APEN_BIT     = 1;
  localparam int GSEL_BIT     = 0;
  localparam int SMM_HI_BIT   = 7;
  localparam int SMM_LO_BIT   = 6;
  localparam logic [7:0] APERTURE_RST = 8'h00;
  localparam logic [7:0] APERTURE_WMASK = 8'h07;
  localparam logic [7:0] ALL_ONES  = 8'hff;
  localparam logic [7:0] ALL_ZEROS = 8'h00;

  typedef enum logic [2:0] {
    PPA_PRE_NONE = 3'b001,
    PPA_PRE_BANK = 3'b010,
    PPA_PRE_ALL  = 3'b100
  } ppa_pre_t;

  typedef struct packed {
    logic       page_miss;
    logic       row_change;
    logic       refresh;
    logic       page_open;
  } ppa_mem_ev_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] dev;
    logic [7:0] ofs;
    logic [7:0] wdata;
  } ppa_cfg_req_t;
endpackage : ppa_pkg

/* src/ppa_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module ppa_regs (
  // clock and reset
  input  wire logic                 CLOCK_I,
  input  wire logic                 RST_N_I,
  // strap pin
  input  wire logic                 FREQ_STRAP_PIN_I,
  // configuration access
  input  wire ppa_pkg::ppa_cfg_req_t CFG_REQ_I,
  input  wire logic                 CFG_PORT_REG_I,
  input  wire logic [7:0]           CFG_DEV_RDATA_I,
  output logic      [7:0]           CFG_RDATA_O,
  output logic                      CFG_DEV2_CLAIM_O,
  // memory controller events
  input  wire ppa_pkg::ppa_mem_ev_t MEM_EV_I,
  output logic                      PRECHARGE_BANK_O,
  output logic                      PRECHARGE_ALL_O,
  // aperture request
  input  wire logic                 APER_REQ_I,
  output logic                      APER_GRANT_O,
  // control levels
  output logic                      FREQ_133_O,
  output logic                      GRAPHICS_INTERNAL_O
);
  logic       strap_s1_q, strap_s2_q;
  logic [1:0] strap_vld_q;
  logic       strap_done_q, strap_done_d;
  logic [7:0] policy_q, policy_d;
  logic [7:0] aper_q, aper_d;
  logic [7:0] smm_q, smm_d;
  logic       lock_used_q, lock_used_d;
  logic [7:0] rdata_q, rdata_d;
  ppa_pkg::ppa_pre_t pre_q, pre_d;
  logic       wr_p, wr_a, wr_s, gsel, smm_on;

  default clocking ppa_cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  assign wr_p   = CFG_REQ_I.wr && CFG_REQ_I.dev == 2'd0
                  && CFG_REQ_I.ofs == ppa_pkg::POLICY_REG_OFS;
  assign wr_a   = CFG_REQ_I.wr && CFG_REQ_I.dev == 2'd0
                  && CFG_REQ_I.ofs == ppa_pkg::APERTURE_REG_OFS;
  assign wr_s   = CFG_REQ_I.wr && CFG_REQ_I.dev == 2'd0
                  && CFG_REQ_I.ofs == ppa_pkg::SMM_REG_OFS;
  assign gsel   = aper_q[ppa_pkg::GSEL_BIT];
  assign smm_on = |smm_q[ppa_pkg::SMM_HI_BIT:ppa_pkg::SMM_LO_BIT];

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      strap_s1_q  <= 1'b0;
      strap_s2_q  <= 1'b0;
      strap_vld_q <= 2'h0;
    end
    else
    begin
      strap_s1_q  <= FREQ_STRAP_PIN_I;
      strap_s2_q  <= strap_s1_q;
      // second flop holds the pin level once both stages have filled
      strap_vld_q <= {strap_vld_q[0], 1'b1};
    end
  end

  always_comb
  begin
    strap_done_d = strap_vld_q[1];
    policy_d     = policy_q;
    aper_d       = aper_q;
    smm_d        = smm_q;
    lock_used_d  = lock_used_q;
    if (strap_vld_q[1] && !strap_done_q)
      policy_d[ppa_pkg::FREQ_BIT] = strap_s2_q;
    if (wr_p && strap_done_q)
    begin
      policy_d[ppa_pkg::POLICY_BIT] = CFG_REQ_I.wdata[ppa_pkg::POLICY_BIT];
      policy_d[ppa_pkg::FREQ_BIT]   = CFG_REQ_I.wdata[ppa_pkg::FREQ_BIT];
    end
    if (wr_s)
      smm_d = CFG_REQ_I.wdata;
    if (wr_a)
    begin
      aper_d[ppa_pkg::APEN_BIT] = CFG_REQ_I.wdata[ppa_pkg::APEN_BIT];
      if (!aper_q[ppa_pkg::LOCK_BIT])
        aper_d[ppa_pkg::GSEL_BIT] = CFG_REQ_I.wdata[ppa_pkg::GSEL_BIT];
      if (!lock_used_q)
      begin
        aper_d[ppa_pkg::LOCK_BIT] = CFG_REQ_I.wdata[ppa_pkg::LOCK_BIT];
        lock_used_d = 1'b1;
      end
      aper_d = aper_d & ppa_pkg::APERTURE_WMASK;
    end
  end

  always_comb
  begin
    rdata_d = ppa_pkg::ALL_ZEROS;
    if (CFG_REQ_I.rd)
    begin
      unique case (CFG_REQ_I.dev)
        2'd0:
        begin
          if (CFG_REQ_I.ofs == ppa_pkg::POLICY_REG_OFS)
            rdata_d = policy_q;
          else if (CFG_REQ_I.ofs == ppa_pkg::APERTURE_REG_OFS)
            rdata_d = aper_q;
          else if (CFG_REQ_I.ofs == ppa_pkg::SMM_REG_OFS)
            rdata_d = smm_q;
          else if (gsel && CFG_PORT_REG_I)
            rdata_d = ppa_pkg::ALL_ZEROS;
          else
            rdata_d = CFG_DEV_RDATA_I;
        end
        2'd1: rdata_d = gsel ? ppa_pkg::ALL_ONES : CFG_DEV_RDATA_I;
        2'd2: rdata_d = (gsel && smm_on) ? CFG_DEV_RDATA_I
                                         : ppa_pkg::ALL_ONES;
        2'd3: rdata_d = ppa_pkg::ALL_ONES;
      endcase
    end
  end

  always_comb
  begin
    pre_d = ppa_pkg::PPA_PRE_NONE;
    if (MEM_EV_I.refresh)
      pre_d = ppa_pkg::PPA_PRE_ALL;
    else if (MEM_EV_I.row_change && MEM_EV_I.page_open)
      pre_d = ppa_pkg::PPA_PRE_ALL;
    else if (MEM_EV_I.page_miss)
      pre_d = policy_q[ppa_pkg::POLICY_BIT] ? ppa_pkg::PPA_PRE_ALL
                                            : ppa_pkg::PPA_PRE_BANK;
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      strap_done_q <= 1'b0;
      policy_q     <= ppa_pkg::ALL_ZEROS;
      aper_q       <= ppa_pkg::APERTURE_RST;
      smm_q        <= ppa_pkg::ALL_ZEROS;
      lock_used_q  <= 1'b0;
      rdata_q      <= ppa_pkg::ALL_ZEROS;
      pre_q        <= ppa_pkg::PPA_PRE_NONE;
    end
    else
    begin
      strap_done_q <= strap_done_d;
      policy_q     <= policy_d;
      aper_q       <= aper_d;
      smm_q        <= smm_d;
      lock_used_q  <= lock_used_d;
      rdata_q      <= rdata_d;
      pre_q        <= pre_d;
    end
  end

  assign CFG_RDATA_O         = rdata_q;
  assign CFG_DEV2_CLAIM_O    = (CFG_REQ_I.rd || CFG_REQ_I.wr)
                               && CFG_REQ_I.dev == 2'd2 && gsel && smm_on;
  assign PRECHARGE_BANK_O    = pre_q == ppa_pkg::PPA_PRE_BANK;
  assign PRECHARGE_ALL_O     = pre_q == ppa_pkg::PPA_PRE_ALL;
  assign APER_GRANT_O        = APER_REQ_I && aper_q[ppa_pkg::APEN_BIT];
  assign FREQ_133_O          = policy_q[ppa_pkg::FREQ_BIT];
  assign GRAPHICS_INTERNAL_O = gsel;

  // strap capture edge, and aperture writes split by lock history
  sequence s_strap_ready;
    strap_vld_q[1] && !strap_done_q;
  endsequence
  sequence s_aper_first_wr;
    wr_a && !lock_used_q;
  endsequence

  a_miss_policy: assert property (
    MEM_EV_I.page_miss && !MEM_EV_I.refresh && !MEM_EV_I.row_change
    && !policy_q[ppa_pkg::POLICY_BIT] |=> PRECHARGE_BANK_O)
    else $error("miss with policy 0 not bank precharge");
  a_miss_closed: assert property (
    MEM_EV_I.page_miss && policy_q[ppa_pkg::POLICY_BIT] |=> PRECHARGE_ALL_O)
    else $error("miss with policy 1 not precharge all");
  a_row_change: assert property (
    MEM_EV_I.row_change && MEM_EV_I.page_open |=> PRECHARGE_ALL_O)
    else $error("row change without precharge all");
  a_refresh_lead: assert property (
    MEM_EV_I.refresh |=> PRECHARGE_ALL_O && !PRECHARGE_BANK_O)
    else $error("refresh without precharge all");
  a_freq_out: assert property (
    wr_p && strap_done_q
    |=> FREQ_133_O == $past(CFG_REQ_I.wdata[ppa_pkg::FREQ_BIT]))
    else $error("frequency write not applied");
  a_strap_take: assert property (
    s_strap_ready |=> FREQ_133_O == $past(strap_s2_q))
    else $error("strap not captured");
  a_lock_take: assert property (
    s_aper_first_wr
    |=> aper_q[ppa_pkg::LOCK_BIT] == $past(CFG_REQ_I.wdata[ppa_pkg::LOCK_BIT]))
    else $error("first lock write not taken");
  a_lock_once: assert property (
    lock_used_q |=> $stable(aper_q[ppa_pkg::LOCK_BIT]))
    else $error("lock changed after first write");
  a_select_locked: assert property (
    aper_q[ppa_pkg::LOCK_BIT] |=> $stable(gsel))
    else $error("select changed while locked");
  a_aper_block: assert property (
    !aper_q[ppa_pkg::APEN_BIT] |-> !APER_GRANT_O)
    else $error("aperture granted while disabled");
  a_dev2_ones: assert property (
    CFG_REQ_I.rd && CFG_REQ_I.dev == 2'd2 && !gsel
    |=> CFG_RDATA_O == ppa_pkg::ALL_ONES)
    else $error("device 2 visible in port mode");
  a_dev1_ones: assert property (
    CFG_REQ_I.rd && CFG_REQ_I.dev == 2'd1 && gsel
    |=> CFG_RDATA_O == ppa_pkg::ALL_ONES)
    else $error("device 1 visible in internal mode");
  a_dev2_claim: assert property (
    CFG_DEV2_CLAIM_O |-> gsel && smm_on)
    else $error("device 2 claimed while gated");
  a_dev2_ignored: assert property (
    CFG_REQ_I.rd && CFG_REQ_I.dev == 2'd2 && !CFG_DEV2_CLAIM_O
    |=> CFG_RDATA_O == ppa_pkg::ALL_ONES)
    else $error("unclaimed device 2 read not all ones");
  a_resv_zero: assert property (
    aper_q[7:3] == 5'h00)
    else $error("reserved aperture bits nonzero");
endmodule : ppa_regs
`default_nettype wire

/* tb/page_policy_aperture_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module page_policy_aperture_config_tb;
  logic                  clk;
  logic                  rst_n;
  logic                  strap;
  ppa_pkg::ppa_cfg_req_t req;
  logic                  port_reg;
  logic [7:0]            dev_rdata;
  logic [7:0]            rdata;
  logic                  claim;
  logic                  claim_seen;
  ppa_pkg::ppa_mem_ev_t  ev;
  logic                  pre_bank;
  logic                  pre_all;
  logic                  aper_req;
  logic                  aper_grant;
  logic                  freq_133;
  logic                  gfx_int;
  int                    err_count;
  int                    checks_done;

  ppa_regs DUT (
    .CLOCK_I            (clk),
    .RST_N_I            (rst_n),
    .FREQ_STRAP_PIN_I   (strap),
    .CFG_REQ_I          (req),
    .CFG_PORT_REG_I     (port_reg),
    .CFG_DEV_RDATA_I    (dev_rdata),
    .CFG_RDATA_O        (rdata),
    .CFG_DEV2_CLAIM_O   (claim),
    .MEM_EV_I           (ev),
    .PRECHARGE_BANK_O   (pre_bank),
    .PRECHARGE_ALL_O    (pre_all),
    .APER_REQ_I         (aper_req),
    .APER_GRANT_O       (aper_grant),
    .FREQ_133_O         (freq_133),
    .GRAPHICS_INTERNAL_O(gfx_int)
  );

  always #12.5 clk = ~clk;

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one request cycle; read data and claim sampled one cycle on
  task automatic acc(input logic w, input logic [1:0] d,
                     input logic [7:0] o, input logic [7:0] wd);
    @(negedge clk);
    req = '{wr: w, rd: !w, dev: d, ofs: o, wdata: wd};
    @(negedge clk);
    claim_seen = claim;
    req = '0;
  endtask : acc

  task automatic rd(input logic [1:0] d, input logic [7:0] o,
                    input logic [7:0] exp, input logic cl);
    acc(1'b0, d, o, 8'h00);
    chk(rdata, exp, "read data");
    chk({7'h00, claim_seen}, {7'h00, cl}, "dev2 claim");
    @(negedge clk);
    chk(rdata, 8'h00, "read data idle");
  endtask : rd

  task automatic mem(input logic [3:0] e, input logic b, input logic a);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = '0;
    chk({6'h00, pre_bank, pre_all}, {6'h00, b, a}, "precharge");
    @(negedge clk);
    chk({6'h00, pre_bank, pre_all}, 8'h00, "precharge one cycle");
  endtask : mem

  task automatic do_reset(input logic s);
    strap = s;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask : do_reset

  initial
  begin
    #50000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    clk = 1'b0;
    req = '0;
    ev = '0;
    port_reg = 1'b0;
    dev_rdata = 8'h5a;
    aper_req = 1'b1;
    err_count = 0;
    checks_done = 0;
    do_reset(1'b1);
    chk({7'h00, freq_133}, 8'h01, "strap freq");
    acc(1'b1, 2'd0, 8'h51, 8'h00);
    rd(2'd0, 8'h51, 8'h00, 1'b0);
    rd(2'd0, 8'h50, 8'h04, 1'b0);
    chk({7'h00, aper_grant}, 8'h00, "aperture blocked");
    acc(1'b1, 2'd0, 8'h50, 8'hff);
    rd(2'd0, 8'h50, 8'h0c, 1'b0);
    mem(4'b1000, 1'b0, 1'b1);
    mem(4'b0101, 1'b0, 1'b1);
    mem(4'b0100, 1'b0, 1'b0);
    mem(4'b0010, 1'b0, 1'b1);
    acc(1'b1, 2'd0, 8'h50, 8'h00);
    chk({7'h00, freq_133}, 8'h00, "freq 100");
    mem(4'b1000, 1'b1, 1'b0);
    mem(4'b1100, 1'b1, 1'b0);
    mem(4'b0101, 1'b0, 1'b1);
    mem(4'b1010, 1'b0, 1'b1);
    $display("test policy and frequency done");
    acc(1'b1, 2'd0, 8'h51, 8'hfb);
    rd(2'd0, 8'h51, 8'h03, 1'b0);
    chk({6'h00, aper_grant, gfx_int}, 8'h03, "enable and select");
    aper_req = 1'b0;
    @(negedge clk);
    chk({7'h00, aper_grant}, 8'h00, "no request no grant");
    aper_req = 1'b1;
    rd(2'd1, 8'h00, 8'hff, 1'b0);
    port_reg = 1'b1;
    rd(2'd0, 8'h08, 8'h00, 1'b0);
    port_reg = 1'b0;
    rd(2'd0, 8'h08, 8'h5a, 1'b0);
    rd(2'd2, 8'h00, 8'hff, 1'b0);
    acc(1'b1, 2'd0, 8'h70, 8'h40);
    rd(2'd2, 8'h00, 8'h5a, 1'b1);
    acc(1'b1, 2'd0, 8'h51, 8'h04);
    rd(2'd0, 8'h51, 8'h00, 1'b0);
    rd(2'd1, 8'h00, 8'h5a, 1'b0);
    rd(2'd2, 8'h00, 8'hff, 1'b0);
    port_reg = 1'b1;
    rd(2'd0, 8'h08, 8'h5a, 1'b0);
    chk({7'h00, aper_grant}, 8'h00, "aperture off");
    port_reg = 1'b0;
    $display("test aperture and visibility done");
    do_reset(1'b0);
    chk({7'h00, freq_133}, 8'h00, "strap low");
    acc(1'b1, 2'd0, 8'h51, 8'h05);
    acc(1'b1, 2'd0, 8'h51, 8'h00);
    rd(2'd0, 8'h51, 8'h05, 1'b0);
    chk({7'h00, gfx_int}, 8'h01, "select held");
    $display("test lock done");
    final_report();
  end
endmodule : page_policy_aperture_config_tb
`default_nettype wire
